// >>> rtl/bhfc_consts.vh
/*
 * Shared constants of the buttonhole fault checker: fault codes and
 * indices, revision limits, lengths and timing.
 * Assumes lengths arrive in units of 0.1 mm and a 20 MHz core clock.
 */
`ifndef BHFC_CONSTS_VH
`define BHFC_CONSTS_VH

// Core clock rate
`define BHFC_CLK_KHZ        20000

// Knife return watch time
`define BHFC_KNIFE_TMO_MS   500
// 500 ms of 20 MHz cycles, sized to the timer width
`define BHFC_KNIFE_TMO_CYC  24'h989680
`define BHFC_TMR_W          24

// Length limits in 0.1 mm units
`define BHFC_MIN_TIMING_LEN 10'h014
`define BHFC_TAPER_MARGIN   10'h001

// Revision boundary of the knife timing check
`define BHFC_REV_OLD_MAX    16'h004e
`define BHFC_REV_NEW_MIN    16'h004f

// Fault flag indices, lowest index has the lowest code
`define BHFC_NF             9
`define BHFC_FI_MOTION      0
`define BHFC_FI_PRESSER     1
`define BHFC_FI_KSIZE       2
`define BHFC_FI_KTIME       3
`define BHFC_FI_PATTERN     4
`define BHFC_FI_START       5
`define BHFC_FI_COMP        6
`define BHFC_FI_EYE_WID     7
`define BHFC_FI_EYE_LEN     8

// Displayed fault codes
`define BHFC_CODE_W         7
`define BHFC_CODE_NONE      7'h00
`define BHFC_CODE_MOTION    7'h0d
`define BHFC_CODE_PRESSER   7'h0e
`define BHFC_CODE_KSIZE     7'h0f
`define BHFC_CODE_KTIME     7'h10
`define BHFC_CODE_PATTERN   7'h11
`define BHFC_CODE_START     7'h12
`define BHFC_CODE_COMP      7'h13
`define BHFC_CODE_EYE_WID   7'h1e
`define BHFC_CODE_EYE_LEN   7'h1f

`endif

// >>> rtl/bhfc_pat_mem.v
/*
 * Pattern validity store: one valid bit per pattern number, with a
 * registered read port.
 * Assumes writer and reader share core_clk; contents clear on reset.
 */
`timescale 1ns/100ps

module bhfc_pat_mem #(
  parameter AW = 4
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          sys_rst,
  // Write side
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire          wr_valid,
  // Read side
  input  wire [AW-1:0] rd_addr,
  output reg           rd_valid_q
);

  reg [(1<<AW)-1:0] valid_q;

  // Unwritten patterns read as invalid after reset
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q    <= {(1<<AW){1'b0}};
      rd_valid_q <= 1'b0;
    end else begin
      if (wr_en) begin
        valid_q[wr_addr] <= wr_valid;
      end
      rd_valid_q <= valid_q[rd_addr];
    end
  end

endmodule

// >>> rtl/bhfc_checker.v
/*
 * Buttonhole fault checker: knife return watchdog, operator parameter
 * checks, latched fault flags, code display and start inhibit.
 * Assumes geometry inputs come from the parameter store on core_clk and
 * stay stable from check_req until check_done; switch and key are pins.
 */
`timescale 1ns/100ps
`include "bhfc_consts.vh"

// Contract
// R1: Knife return switch unchanged 500 ms after energising raises knife motion fault.
// R2: Reset key clears knife motion fault; sewing may then start again.
// R3: Total length longer than presser length raises presser size fault.
// R4: Stitch plus groove width above half presser width raises presser size fault.
// R5: Multi-cut with knife size above cut length raises knife size fault.
// R6: Multi-cut where knife bar would hit clamp raises knife size fault.
// R7: Old revisions: second bar plus clearance under 2 mm raises timing fault.
// R8: New revisions, double stitch: bar plus clearance under 2 mm raises timing fault.
// R9: New revisions: two strokes needed after jump feed raises timing fault.
// R10: Invalid stored data for selected pattern raises cycle pattern fault.
// R11: Start position beyond bar-tack length raises start position fault.
// R12: Start position plus stitches times pitch beyond bar-tack raises start fault.
// R13: Taper: doubled left comp plus start run above bar minus 0.1 mm faults.
// R14: Either side stitch, groove, compensation above half presser raises compensation fault.
// R15: Taper with positive compensation raises compensation fault.
// R16: Taper with doubled compensation above bar-tack length raises compensation fault.
// R17: Taper bar width below stitch width raises compensation fault.
// R18: Overedge, eyelet radius, groove above half presser width raises eyelet width fault.
// R19: Eyelet tail overlapping second bar-tack raises eyelet length fault.
// R20: Parameter faults clear only on reset key; operator re-enters data.
// R21: Any fault shows its numeric code on the panel display.
// R22: Any latched fault inhibits starting a new sewing cycle.
// R23: Several faults at once report the lowest-numbered code.
module bhfc_checker #(
  parameter                  W             = 10,
  parameter                  CW            = 6,
  parameter                  AW            = 4,
  parameter [`BHFC_TMR_W-1:0] KNIFE_TMO_CYC = `BHFC_KNIFE_TMO_CYC
) (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // Knife actuator and return sensor
  input  wire                   knife_drive,
  input  wire                   knife_ret_sw,
  output wire                   knife_watch,
  // Control panel
  input  wire                   reset_key,
  input  wire                   start_req,
  output wire                   cycle_start,
  output reg                    fault_any_q,
  output reg  [`BHFC_CODE_W-1:0] fault_code_q,
  output reg  [`BHFC_NF-1:0]    fault_flags_q,
  // Check handshake
  input  wire                   check_req,
  output reg                    check_done_q,
  output reg                    check_pass_q,
  input  wire [15:0]            firmware_revision,
  // Pattern store
  input  wire [AW-1:0]          pattern_no,
  input  wire                   pat_wr_en,
  input  wire [AW-1:0]          pat_wr_addr,
  input  wire                   pat_wr_valid,
  // Presser and knife geometry
  input  wire [W-1:0]           presser_len,
  input  wire [W-1:0]           presser_wid,
  input  wire [W-1:0]           total_len,
  input  wire [W-1:0]           stitch_wid,
  input  wire [W-1:0]           groove_l,
  input  wire [W-1:0]           groove_r,
  input  wire                   multi_cut,
  input  wire [W-1:0]           knife_size,
  input  wire [W-1:0]           cut_len,
  // Bar-tacks
  input  wire                   taper_mode,
  input  wire [W-1:0]           comp_l,
  input  wire                   comp_l_neg,
  input  wire [W-1:0]           comp_r,
  input  wire                   comp_r_neg,
  input  wire [W-1:0]           bar_len,
  input  wire [W-1:0]           bar2_len,
  input  wire [W-1:0]           clear2,
  input  wire                   double_stitch,
  input  wire                   jump_feed,
  // Sewing start
  input  wire [W-1:0]           start_pos,
  input  wire [CW-1:0]          start_cnt,
  input  wire [W-1:0]           start_pitch,
  // Eyelet
  input  wire                   eyelet_mode,
  input  wire [W-1:0]           overedge_wid,
  input  wire [W-1:0]           eyelet_rad,
  input  wire [W-1:0]           eyelet_tail
);

  localparam XW = W + 8;

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_WATCH = 2'b10;

  // Extend to the working width so sums and doubles cannot overflow
  function [XW-1:0] ext;
    input [W-1:0] v;
    begin
      ext = {{(XW-W){1'b0}}, v};
    end
  endfunction

  function [XW-1:0] dbl;
    input [XW-1:0] v;
    begin
      dbl = {v[XW-2:0], 1'b0};
    end
  endfunction

  function [`BHFC_CODE_W-1:0] code_of;
    input integer idx;
    begin
      case (idx)
        `BHFC_FI_MOTION:  code_of = `BHFC_CODE_MOTION;
        `BHFC_FI_PRESSER: code_of = `BHFC_CODE_PRESSER;
        `BHFC_FI_KSIZE:   code_of = `BHFC_CODE_KSIZE;
        `BHFC_FI_KTIME:   code_of = `BHFC_CODE_KTIME;
        `BHFC_FI_PATTERN: code_of = `BHFC_CODE_PATTERN;
        `BHFC_FI_START:   code_of = `BHFC_CODE_START;
        `BHFC_FI_COMP:    code_of = `BHFC_CODE_COMP;
        `BHFC_FI_EYE_WID: code_of = `BHFC_CODE_EYE_WID;
        `BHFC_FI_EYE_LEN: code_of = `BHFC_CODE_EYE_LEN;
        default:          code_of = `BHFC_CODE_NONE;
      endcase
    end
  endfunction

  // Pin synchronisers
  reg                    ret_s1_q;
  reg                    ret_s2_q;
  reg                    key_s1_q;
  reg                    key_s2_q;
  reg                    key_prev_q;
  // Knife watchdog
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg  [`BHFC_TMR_W-1:0] tmr_q;
  reg  [`BHFC_TMR_W-1:0] tmr_d;
  reg                    ret_ref_q;
  reg                    drive_prev_q;
  reg                    motion_set;
  // Parameter check
  reg                    chk_pend_q;
  wire                   pat_valid;
  reg  [`BHFC_NF-1:0]    chk_set;
  reg  [`BHFC_NF-1:0]    fault_set;
  reg  [`BHFC_NF-1:0]    flags_d;
  reg  [`BHFC_CODE_W-1:0] code_d;
  integer                i;

  wire key_press  = key_s2_q & ~key_prev_q;
  wire drive_rise = knife_drive & ~drive_prev_q;
  wire ret_moved  = ret_s2_q ^ ret_ref_q;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ret_s1_q   <= 1'b0;
      ret_s2_q   <= 1'b0;
      key_s1_q   <= 1'b0;
      key_s2_q   <= 1'b0;
      key_prev_q <= 1'b0;
    end else begin
      ret_s1_q   <= knife_ret_sw;
      ret_s2_q   <= ret_s1_q;
      key_s1_q   <= reset_key;
      key_s2_q   <= key_s1_q;
      key_prev_q <= key_s2_q;
    end
  end

  // R1: knife return watchdog
  always @* begin
    state_d    = state_q;
    tmr_d      = tmr_q;
    motion_set = 1'b0;
    case (state_q)
      ST_IDLE: begin
        tmr_d = {`BHFC_TMR_W{1'b0}};
        if (drive_rise) begin
          state_d = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (ret_moved) begin
          state_d = ST_IDLE;
        end else if (tmr_q == KNIFE_TMO_CYC - 1'b1) begin
          motion_set = 1'b1;
          state_d    = ST_IDLE;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        tmr_d   = {`BHFC_TMR_W{1'b0}};
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= ST_IDLE;
      tmr_q        <= {`BHFC_TMR_W{1'b0}};
      ret_ref_q    <= 1'b0;
      drive_prev_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      tmr_q        <= tmr_d;
      drive_prev_q <= knife_drive;
      // Switch level at the moment of energising is the reference
      if (state_q == ST_IDLE) begin
        ret_ref_q <= ret_s2_q;
      end
    end
  end

  assign knife_watch = state_q[1];

  bhfc_pat_mem #(
    .AW(AW)
  ) u_pat_mem (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .wr_en      (pat_wr_en),
    .wr_addr    (pat_wr_addr),
    .wr_valid   (pat_wr_valid),
    .rd_addr    (pattern_no),
    .rd_valid_q (pat_valid)
  );

  // Working-width operands
  wire [XW-1:0] pw   = ext(presser_wid);
  wire [XW-1:0] sw   = ext(stitch_wid);
  wire [XW-1:0] gl   = ext(groove_l);
  wire [XW-1:0] gr   = ext(groove_r);
  wire [XW-1:0] bl   = ext(bar_len);
  wire [XW-1:0] sp   = ext(start_pos);
  wire [XW-1:0] cl   = ext(cut_len);
  wire [XW-1:0] ks   = ext(knife_size);
  wire [XW-1:0] c2   = ext(clear2);
  wire [XW-1:0] lim  = ext(`BHFC_MIN_TIMING_LEN);
  wire [XW-1:0] pos_l = (comp_l_neg) ? {XW{1'b0}} : ext(comp_l);
  wire [XW-1:0] neg_l = (comp_l_neg) ? ext(comp_l) : {XW{1'b0}};
  wire [XW-1:0] pos_r = (comp_r_neg) ? {XW{1'b0}} : ext(comp_r);
  wire [XW-1:0] neg_r = (comp_r_neg) ? ext(comp_r) : {XW{1'b0}};

  // Two or fewer starting stitches add no run-in to the taper run (run_m2)
  wire [CW-1:0] cnt_m2 = (start_cnt > 2'd2) ? start_cnt - 2'd2 : {CW{1'b0}};
  wire [XW-1:0] run_all = {{(XW-CW){1'b0}}, start_cnt} * ext(start_pitch);
  wire [XW-1:0] run_m2  = {{(XW-CW){1'b0}}, cnt_m2} * ext(start_pitch);

  wire [XW-1:0] side_l = sw + gl + pos_l;
  wire [XW-1:0] side_r = sw + gr + pos_r;
  wire [XW-1:0] eye_l  = ext(overedge_wid) + ext(eyelet_rad) + gl;
  wire [XW-1:0] eye_r  = ext(overedge_wid) + ext(eyelet_rad) + gr;

  wire old_rev = firmware_revision <= `BHFC_REV_OLD_MAX;
  wire new_rev = firmware_revision >= `BHFC_REV_NEW_MIN;

  // Half-width limits are compared doubled so odd widths do not round
  // R3: total length vs presser
  wire len_over     = total_len > presser_len;
  // R4: width vs half presser
  wire wid_over     = (dbl(sw + gl) > pw) || (dbl(sw + gr) > pw);
  // R5: knife over cut length
  wire knife_long   = multi_cut && (ks > cl);
  // R6: knife bar hits clamp
  wire bar_clamp    = multi_cut && ((cl + ks) > ext(presser_len));
  // R7: old revision timing
  wire tm_old       = old_rev && ((ext(bar2_len) + c2) < lim);
  // R8: double stitch timing
  wire tm_double    = new_rev && double_stitch && ((bl + c2) < lim);
  // R9: two strokes after jump
  wire tm_jump      = new_rev && jump_feed && (cl > (ks + c2));
  // R11: start beyond bar
  wire start_over   = sp > bl;
  // R12: start run beyond bar
  wire run_over     = (sp + run_all) > bl;
  // R13: taper start run
  wire taper_run    = taper_mode && ((dbl(ext(comp_l)) + sp + run_m2 + ext(`BHFC_TAPER_MARGIN)) > bl);
  // R14: per-side compensation
  wire side_over    = (dbl(side_l) > (pw + dbl(neg_l))) || (dbl(side_r) > (pw + dbl(neg_r)));
  // R15: taper positive comp
  wire taper_pos    = taper_mode && ((pos_l != {XW{1'b0}}) || (pos_r != {XW{1'b0}}));
  // R16: taper doubled comp
  wire taper_dbl    = taper_mode && ((dbl(ext(comp_l)) > bl) || (dbl(ext(comp_r)) > bl));
  // R17: taper bar narrower than stitch
  wire taper_narrow = taper_mode && ((gr + gl + sw + neg_l + neg_r) < (pos_l + pos_r));
  // R18: eyelet width
  wire eye_wide     = eyelet_mode && ((dbl(eye_l) > pw) || (dbl(eye_r) > pw));
  // R19: eyelet tail overlap
  wire eye_long     = eyelet_mode && (ext(eyelet_tail) > cl);

  always @* begin
    chk_set                   = {`BHFC_NF{1'b0}};
    chk_set[`BHFC_FI_PRESSER] = len_over | wid_over;
    chk_set[`BHFC_FI_KSIZE]   = knife_long | bar_clamp;
    chk_set[`BHFC_FI_KTIME]   = tm_old | tm_double | tm_jump;
    // R10: pattern data validity
    chk_set[`BHFC_FI_PATTERN] = ~pat_valid;
    chk_set[`BHFC_FI_START]   = start_over | run_over | taper_run;
    chk_set[`BHFC_FI_COMP]    = side_over | taper_pos | taper_dbl | taper_narrow;
    chk_set[`BHFC_FI_EYE_WID] = eye_wide;
    chk_set[`BHFC_FI_EYE_LEN] = eye_long;
  end

  // R2: reset key clears, a new event in the same cycle still wins
  // R20: parameter faults cleared only by the key
  always @* begin
    fault_set = (chk_pend_q) ? chk_set : {`BHFC_NF{1'b0}};
    fault_set[`BHFC_FI_MOTION] = motion_set;
    flags_d = fault_flags_q;
    if (key_press) begin
      flags_d = {`BHFC_NF{1'b0}};
    end
    flags_d = flags_d | fault_set;
  end

  // R23: lowest code wins
  // R21: code shown on panel
  always @* begin
    code_d = `BHFC_CODE_NONE;
    for (i = `BHFC_NF - 1; i >= 0; i = i - 1) begin
      if (flags_d[i]) begin
        code_d = code_of(i);
      end
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chk_pend_q    <= 1'b0;
      check_done_q  <= 1'b0;
      check_pass_q  <= 1'b0;
      fault_flags_q <= {`BHFC_NF{1'b0}};
      fault_any_q   <= 1'b0;
      fault_code_q  <= `BHFC_CODE_NONE;
    end else begin
      // One cycle wait covers the registered pattern store read
      chk_pend_q    <= check_req;
      check_done_q  <= chk_pend_q;
      if (chk_pend_q) begin
        check_pass_q <= (chk_set == {`BHFC_NF{1'b0}});
      end
      fault_flags_q <= flags_d;
      fault_any_q   <= |flags_d;
      fault_code_q  <= code_d;
    end
  end

  // R22: start inhibit while latched
  assign cycle_start = start_req & ~fault_any_q;

endmodule

// >>> verif/bhfc_checker_properties.sv
/*
 * Concurrent checks on the buttonhole fault checker's top ports.
 * Assumes one core_clk domain and the async active high sys_rst.
 */
`timescale 1ns/100ps
`include "bhfc_consts.vh"

module bhfc_checker_props #(
  parameter [`BHFC_TMR_W-1:0] KNIFE_TMO_CYC = 24'h000014
) (
  // Clock and reset
  input wire                      core_clk,
  input wire                      sys_rst,
  // Knife and panel
  input wire                      knife_drive,
  input wire                      knife_watch,
  input wire                      reset_key,
  input wire                      start_req,
  input wire                      cycle_start,
  input wire                      fault_any_q,
  input wire [`BHFC_CODE_W-1:0]   fault_code_q,
  input wire [`BHFC_NF-1:0]       fault_flags_q,
  // Check handshake
  input wire                      check_req,
  input wire                      check_done_q,
  input wire                      check_pass_q
);
  reg [7:0]             key_age_q;
  reg [`BHFC_TMR_W-1:0] wcnt_q;

  // Saturating age of the last key press; watch length in cycles
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_age_q <= 8'hff;
      wcnt_q    <= {`BHFC_TMR_W{1'b0}};
    end else begin
      key_age_q <= reset_key ? 8'h00 : (key_age_q == 8'hff ? key_age_q : key_age_q + 8'h01);
      wcnt_q    <= knife_watch ? wcnt_q + 1'b1 : {`BHFC_TMR_W{1'b0}};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_arm;
    !knife_drive ##1 (knife_drive && !knife_watch);
  endsequence
  sequence s_check;
    check_req ##2 check_done_q;
  endsequence

  AST_KNIFE_ARM: assert property (s_arm |=> knife_watch)
    else $error("knife watch not started on drive rise");
  AST_MOTION_TIME: assert property ($rose(fault_flags_q[0]) |->
    wcnt_q >= KNIFE_TMO_CYC - 1 && wcnt_q <= KNIFE_TMO_CYC + 1)
    else $error("knife motion fault at wrong time");
  AST_WATCH_MAX: assert property (wcnt_q <= KNIFE_TMO_CYC + 1)
    else $error("knife watch ran too long");
  AST_START_GATE: assert property (cycle_start == (start_req && !fault_any_q))
    else $error("start not gated by latched fault");
  AST_ANY_FLAG: assert property (fault_any_q == (|fault_flags_q))
    else $error("fault_any disagrees with flags");
  AST_CODE_SHOWN: assert property ((fault_code_q == 7'h00) == !fault_any_q)
    else $error("display code disagrees with fault state");
  AST_CODE_MOTION: assert property (fault_flags_q[0] |-> fault_code_q == 7'h0d)
    else $error("motion fault not shown first");
  AST_DONE_TWO: assert property (check_req |-> s_check)
    else $error("check done not two cycles after request");
  AST_DONE_CAUSE: assert property (check_done_q |-> $past(check_req, 2))
    else $error("check done without request");
  AST_PASS_CLEAN: assert property (check_done_q && check_pass_q |-> $stable(fault_flags_q[8:1]))
    else $error("passing check changed flags");
  AST_STICKY: assert property ((|($past(fault_flags_q) & ~fault_flags_q)) |-> key_age_q < 8'h08)
    else $error("fault flag cleared without key");
endmodule

bind bhfc_checker bhfc_checker_props #(.KNIFE_TMO_CYC(KNIFE_TMO_CYC)) u_bhfc_checker_props (
  .core_clk, .sys_rst, .knife_drive, .knife_watch, .reset_key, .start_req, .cycle_start,
  .fault_any_q, .fault_code_q, .fault_flags_q, .check_req, .check_done_q, .check_pass_q);

// >>> verif/bhfc_knife_model.sv
/*
 * Knife actuator and return sensor: the switch changes level a set
 * number of cycles after the actuator is energised.
 * Assumes the drive is a level on core_clk; ret_dly of 0 never returns.
 */
`timescale 1ns/100ps

module bhfc_knife_model (
  // Clock
  input  wire       core_clk,
  // Actuator side
  input  wire       knife_drive,
  input  wire [7:0] ret_dly,
  // Sensor pin
  output reg        knife_ret_sw = 1'b0
);
  reg       drive_q = 1'b0;
  reg [7:0] cnt_q   = 8'h00;

  always @(posedge core_clk) begin
    drive_q <= knife_drive;
    if (knife_drive && !drive_q)
      cnt_q <= ret_dly;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
    // return shown as a level change
    if (cnt_q == 8'h01)
      knife_ret_sw <= ~knife_ret_sw;
  end
endmodule

// >>> verif/bhfc_checker_tb_top.sv
/*
 * Bench of the buttonhole fault checker: knife watchdog, key clear,
 * start inhibit and a table of parameter checks.
 * Assumes the knife model and a shortened knife timeout.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module bhfc_checker_tb_top;
  logic       core_clk = 0, sys_rst = 1, knife_drive = 0, reset_key = 0, start_req = 0, check_req = 0;
  logic       pat_wr_en = 0, pat_wr_valid = 0, multi_cut, taper_mode, comp_l_neg, comp_r_neg;
  logic       double_stitch, jump_feed, eyelet_mode;
  logic [3:0] pattern_no, pat_wr_addr = 0;
  logic [5:0] start_cnt;
  logic [7:0] ret_dly = 8'h03;
  logic [15:0] firmware_revision;
  logic [9:0] presser_len, presser_wid, total_len, stitch_wid, groove_l, groove_r, knife_size, cut_len;
  logic [9:0] comp_l, comp_r, bar_len, bar2_len, clear2, start_pos, start_pitch;
  logic [9:0] overedge_wid, eyelet_rad, eyelet_tail;
  wire        knife_ret_sw, knife_watch, cycle_start, fault_any_q, check_done_q, check_pass_q;
  wire [6:0]  fault_code_q;
  wire [8:0]  fault_flags_q;
  int         n_errors = 0, comparisons = 0, cycles = 0;
  logic [6:0] exp_code [0:17] = '{7'h00, 7'h0e, 7'h0e, 7'h0f, 7'h0f, 7'h00, 7'h10, 7'h10, 7'h10,
                                  7'h11, 7'h12, 7'h12, 7'h12, 7'h13, 7'h13, 7'h13, 7'h1e, 7'h1f};

  always #25 core_clk = ~core_clk;

  bhfc_checker #(.KNIFE_TMO_CYC(24'd20)) u_bhfc_checker (
    .core_clk, .sys_rst, .knife_drive, .knife_ret_sw, .knife_watch, .reset_key, .start_req,
    .cycle_start, .fault_any_q, .fault_code_q, .fault_flags_q, .check_req, .check_done_q,
    .check_pass_q, .firmware_revision, .pattern_no, .pat_wr_en, .pat_wr_addr, .pat_wr_valid,
    .presser_len, .presser_wid, .total_len, .stitch_wid, .groove_l, .groove_r, .multi_cut,
    .knife_size, .cut_len, .taper_mode, .comp_l, .comp_l_neg, .comp_r, .comp_r_neg, .bar_len,
    .bar2_len, .clear2, .double_stitch, .jump_feed, .start_pos, .start_cnt, .start_pitch,
    .eyelet_mode, .overedge_wid, .eyelet_rad, .eyelet_tail);

  bhfc_knife_model u_bhfc_knife_model (.core_clk, .knife_drive, .ret_dly, .knife_ret_sw);

  task final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  // Geometry that passes every check, lengths in 0.1 mm
  task set_good;
    @(posedge core_clk);
    {presser_len, presser_wid, total_len, stitch_wid} <= {10'h190, 10'h064, 10'h12c, 10'h014};
    {groove_l, groove_r, knife_size, cut_len} <= {10'h005, 10'h005, 10'h064, 10'h0c8};
    {comp_l, comp_r, bar_len, bar2_len, clear2} <= {10'h000, 10'h000, 10'h028, 10'h028, 10'h00a};
    {start_pos, start_cnt, start_pitch} <= {10'h005, 6'h02, 10'h003};
    {overedge_wid, eyelet_rad, eyelet_tail} <= {10'h014, 10'h00a, 10'h000};
    {multi_cut, taper_mode, comp_l_neg, comp_r_neg, double_stitch, jump_feed, eyelet_mode} <= 7'h00;
    {firmware_revision, pattern_no} <= {16'h004f, 4'h0};
  endtask

  // Latency counts from the edge that raises the request
  task do_check(output int lat);
    @(posedge core_clk);
    check_req <= 1'b1;
    lat = 0;
    do begin
      @(posedge core_clk);
      check_req <= 1'b0;
      #1;
      lat++;
    end while (check_done_q !== 1'b1 && lat < 8);
  endtask

  task press_key;
    @(posedge core_clk);
    reset_key <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset_key <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task run_case(input int k);
    int lat;
    set_good();
    @(posedge core_clk);
    case (k)
      1: total_len <= 10'h191;
      2: groove_r <= 10'h01f;
      3: {multi_cut, knife_size, presser_len} <= {1'b1, 10'h0c9, 10'h1f4};
      4: {multi_cut, knife_size, cut_len} <= {1'b1, 10'h096, 10'h104};
      5: {firmware_revision, bar2_len} <= {16'h004e, 10'h00a};
      6: {firmware_revision, bar2_len} <= {16'h004e, 10'h009};
      7: {double_stitch, bar_len} <= {1'b1, 10'h009};
      8: {jump_feed, cut_len} <= {1'b1, 10'h06f};
      9: pattern_no <= 4'h1;
      10: start_pos <= 10'h029;
      11: start_cnt <= 6'h0c;
      12: {taper_mode, comp_l, comp_l_neg, start_cnt} <= {1'b1, 10'h005, 1'b1, 6'h0b};
      13: comp_r <= 10'h01a;
      14: {taper_mode, comp_r} <= {1'b1, 10'h001};
      15: {taper_mode, comp_r, comp_r_neg} <= {1'b1, 10'h015, 1'b1};
      16: {eyelet_mode, eyelet_rad} <= {1'b1, 10'h01a};
      17: {eyelet_mode, eyelet_tail} <= {1'b1, 10'h0c9};
      default: ;
    endcase
    do_check(lat);
    `CHK("check_latency", 2, lat)
    `CHK("fault_code", exp_code[k], fault_code_q)
    `CHK("check_pass", exp_code[k] == 7'h00, check_pass_q)
    `CHK("cycle_start", exp_code[k] == 7'h00, cycle_start)
    if (k == 2)
      `CHK("fault_flags", 9'h042, fault_flags_q)
    if (k == 1) begin
      set_good();
      do_check(lat);
      `CHK("sticky_code", 7'h0e, fault_code_q)
    end
    press_key();
    `CHK("flags_cleared", 9'h000, fault_flags_q)
    $display("test %0d done", k);
  endtask

  initial begin
    set_good();
    repeat (1) @(posedge core_clk);
    sys_rst <= 1'b0;
    start_req <= 1'b1;
    {pat_wr_en, pat_wr_valid} <= 2'b11;
    @(posedge core_clk);
    pat_wr_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("idle_start", 1'b1, cycle_start)
    @(posedge core_clk);
    knife_drive <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    `CHK("prompt_return", 1'b0, fault_flags_q[0])
    @(posedge core_clk);
    {knife_drive, ret_dly} <= {1'b0, 8'h28};
    repeat (3) @(posedge core_clk);
    knife_drive <= 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
    `CHK("motion_code", 7'h0d, fault_code_q)
    `CHK("start_blocked", 1'b0, cycle_start)
    @(posedge core_clk);
    knife_drive <= 1'b0;
    press_key();
    `CHK("motion_cleared", 9'h000, fault_flags_q)
    `CHK("restart", 1'b1, cycle_start)
    $display("test knife done");
    for (int k = 0; k < 18; k++)
      run_case(k);
    final_report();
  end
endmodule
